// ---- tmr_pkg.sv ----
// tmr_pkg: register map, reset values, field positions and timing constants
// for the temperature monitor register bank.
// assumes: byte-wide register port driven by a serial protocol engine.
package tmr_pkg;

  // read addresses
  localparam logic [7:0] RA_LOCAL_VAL = 8'h00;
  localparam logic [7:0] RA_REM_VAL_HI = 8'h01;
  localparam logic [7:0] RA_STATUS1 = 8'h02;
  localparam logic [7:0] RA_CFG1 = 8'h03;
  localparam logic [7:0] RA_RATE = 8'h04;
  localparam logic [7:0] RA_LOC_HI = 8'h05;
  localparam logic [7:0] RA_LOC_LO = 8'h06;
  localparam logic [7:0] RA_REM_HI_HB = 8'h07;
  localparam logic [7:0] RA_REM_LO_HB = 8'h08;
  localparam logic [7:0] RA_REM_VAL_LO = 8'h10;
  localparam logic [7:0] RA_STATUS2 = 8'h23;
  localparam logic [7:0] RA_CH2_VAL_HI = 8'h30;
  localparam logic [7:0] RA_CH2_VAL_LO = 8'h33;
  localparam logic [7:0] RA_PART_ID = 8'h3D;
  localparam logic [7:0] RA_MAKER_ID = 8'h3E;
  // write addresses that differ from the read ones
  localparam logic [7:0] WA_CFG1 = 8'h09;
  localparam logic [7:0] WA_RATE = 8'h0A;
  localparam logic [7:0] WA_LOC_HI = 8'h0B;
  localparam logic [7:0] WA_LOC_LO = 8'h0C;
  localparam logic [7:0] WA_REM_HI_HB = 8'h0D;
  localparam logic [7:0] WA_REM_LO_HB = 8'h0E;
  localparam logic [7:0] WA_ONE_SHOT = 8'h0F;
  // same address for read and write
  localparam logic [7:0] A_REM_OFS_HI = 8'h11;
  localparam logic [7:0] A_REM_OFS_LO = 8'h12;
  localparam logic [7:0] A_REM_HI_LB = 8'h13;
  localparam logic [7:0] A_REM_LO_LB = 8'h14;
  localparam logic [7:0] A_REM_OT = 8'h19;
  localparam logic [7:0] A_LOC_OT = 8'h20;
  localparam logic [7:0] A_HYST = 8'h21;
  localparam logic [7:0] A_FILT = 8'h22;
  localparam logic [7:0] A_CFG2 = 8'h24;
  localparam logic [7:0] A_CH2_HI_HB = 8'h31;
  localparam logic [7:0] A_CH2_LO_HB = 8'h32;
  localparam logic [7:0] A_CH2_OFS_HI = 8'h34;
  localparam logic [7:0] A_CH2_OFS_LO = 8'h35;
  localparam logic [7:0] A_CH2_HI_LB = 8'h36;
  localparam logic [7:0] A_CH2_LO_LB = 8'h37;
  localparam logic [7:0] A_CH2_OT = 8'h39;

  // storage slots of the writable registers
  localparam int unsigned NSLOT = 22;
  localparam logic [4:0] S_CFG1 = 5'h00;
  localparam logic [4:0] S_RATE = 5'h01;
  localparam logic [4:0] S_LHI = 5'h02;
  localparam logic [4:0] S_LLO = 5'h03;
  localparam logic [4:0] S_R1HH = 5'h04;
  localparam logic [4:0] S_R1LH = 5'h05;
  localparam logic [4:0] S_R1OH = 5'h06;
  localparam logic [4:0] S_R1OL = 5'h07;
  localparam logic [4:0] S_R1HL = 5'h08;
  localparam logic [4:0] S_R1LL = 5'h09;
  localparam logic [4:0] S_R1OT = 5'h0A;
  localparam logic [4:0] S_LOT = 5'h0B;
  localparam logic [4:0] S_HYST = 5'h0C;
  localparam logic [4:0] S_FILT = 5'h0D;
  localparam logic [4:0] S_CFG2 = 5'h0E;
  localparam logic [4:0] S_R2HH = 5'h0F;
  localparam logic [4:0] S_R2LH = 5'h10;
  localparam logic [4:0] S_R2OH = 5'h11;
  localparam logic [4:0] S_R2OL = 5'h12;
  localparam logic [4:0] S_R2HL = 5'h13;
  localparam logic [4:0] S_R2LL = 5'h14;
  localparam logic [4:0] S_R2OT = 5'h15;
  // values after reset, indexed by slot
  localparam logic [7:0] RST_VAL [NSLOT] = '{
    8'h00, 8'h07, 8'h55, 8'h00, 8'h55, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h55,
    8'h55, 8'h0A, 8'h01, 8'h00, 8'h55, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h55};
  localparam logic [7:0] RST_MEAS = 8'h00;

  // field positions
  localparam int unsigned CFG1_ALT_BIT = 3;
  localparam int unsigned CFG1_STANDBY_BIT = 6;
  localparam int unsigned FILT_SCL_BIT = 7;
  localparam int unsigned FILT_SDA_BIT = 6;
  localparam int unsigned FILT_MASK_LOC_BIT = 5;
  localparam logic [7:0] FILT_WR_MASK = 8'hEF;
  localparam int unsigned NLIM = 6;

  // bus timeout
  localparam int unsigned TIMEOUT_MS = 25;
  localparam int unsigned CLK_KHZ = 200000;
  localparam int unsigned TIMEOUT_CYC = TIMEOUT_MS * CLK_KHZ;

  // one measurement set from the conversion engine
  typedef struct packed {
    logic [7:0] local_val;
    logic [7:0] r1_hi;
    logic [7:0] r1_lo;
    logic [7:0] r2_hi;
    logic [7:0] r2_lo;
  } tmr_meas_t;

endpackage

// ---- tmr_regbank.sv ----
// tmr_regbank: register bank, one-shot trigger, fault count filter and bus
// timeout watchdog of a three channel temperature monitor.
// assumes: a protocol engine on clk_i delivers pointer, write and read
// strobes; scl/sda arrive raw from the pins; measurements come as pulses.
//
// What this block does
// - standby write to one-shot address starts conversion
// - one-shot address stores nothing, data ignored
// - fault count field decodes 1 to 4
// - default one fault, four at most
// - bit 7 enables clock-line timeout, resets 0
// - bit 6 enables data-line timeout, resets 0
// - bit 5 masks local limit alarms
// - bit 4 reserved, no function
// - rate register read 0x04, written 0x0A
// - local limits split read/write addresses, defaults
// - remote limit high bytes split addresses
// - shared remote addresses follow configuration bit 3
// - remote low value byte is read-only
// - hysteresis at 0x21 resets to 0x0A
// - filter register at 0x22 resets to 0x01
// - second status read-only at 0x23
// - channel 2 dedicated addresses, value bytes read-only
// - enabled timeout abandons idle transaction after 25 ms
// - bit 3 redirects offsets to channel 2
`timescale 1ns/100ps
`default_nettype none

module tmr_regbank #(
  parameter int unsigned TIMEOUT_CYC = tmr_pkg::TIMEOUT_CYC,
  parameter logic [7:0] PART_ID = 8'h5A, // arbitrary value
  parameter logic [7:0] MAKER_ID = 8'h3C // arbitrary value
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // register port from the protocol engine
  input wire logic ptr_wr_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o,
  output logic rvalid_o,
  // bus pins and transaction state
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic bus_busy_i,
  output logic bus_abort_o,
  // measurement engine
  input wire logic meas_valid_i,
  input wire tmr_pkg::tmr_meas_t meas_i,
  input wire logic [7:0] status_first_i,
  input wire logic [7:0] status_second_i,
  output logic conv_start_o,
  output logic [7:0] rate_sel_o,
  output logic [7:0] config_first_o,
  output logic [7:0] hysteresis_o,
  // filtered limit alarm
  output logic fault_alert_o
);

  // register map lookup: returns {hit, slot}, write addresses when is_wr
  function automatic logic [5:0] map_addr(input logic [7:0] a, input logic alt,
                                          input logic is_wr);
    logic [5:0] r;
    r = 6'h00;
    if (a == (is_wr ? tmr_pkg::WA_CFG1 : tmr_pkg::RA_CFG1)) r = {1'b1, tmr_pkg::S_CFG1};
    if (a == (is_wr ? tmr_pkg::WA_RATE : tmr_pkg::RA_RATE)) r = {1'b1, tmr_pkg::S_RATE};
    if (a == (is_wr ? tmr_pkg::WA_LOC_HI : tmr_pkg::RA_LOC_HI)) r = {1'b1, tmr_pkg::S_LHI};
    if (a == (is_wr ? tmr_pkg::WA_LOC_LO : tmr_pkg::RA_LOC_LO)) r = {1'b1, tmr_pkg::S_LLO};
    if (a == (is_wr ? tmr_pkg::WA_REM_HI_HB : tmr_pkg::RA_REM_HI_HB))
      r = {1'b1, alt ? tmr_pkg::S_R2HH : tmr_pkg::S_R1HH};
    if (a == (is_wr ? tmr_pkg::WA_REM_LO_HB : tmr_pkg::RA_REM_LO_HB))
      r = {1'b1, alt ? tmr_pkg::S_R2LH : tmr_pkg::S_R1LH};
    unique case (a)
      tmr_pkg::A_REM_OFS_HI: r = {1'b1, alt ? tmr_pkg::S_R2OH : tmr_pkg::S_R1OH};
      tmr_pkg::A_REM_OFS_LO: r = {1'b1, alt ? tmr_pkg::S_R2OL : tmr_pkg::S_R1OL};
      tmr_pkg::A_REM_HI_LB: r = {1'b1, alt ? tmr_pkg::S_R2HL : tmr_pkg::S_R1HL};
      tmr_pkg::A_REM_LO_LB: r = {1'b1, alt ? tmr_pkg::S_R2LL : tmr_pkg::S_R1LL};
      tmr_pkg::A_REM_OT: r = {1'b1, alt ? tmr_pkg::S_R2OT : tmr_pkg::S_R1OT};
      tmr_pkg::A_LOC_OT: r = {1'b1, tmr_pkg::S_LOT};
      tmr_pkg::A_HYST: r = {1'b1, tmr_pkg::S_HYST};
      tmr_pkg::A_FILT: r = {1'b1, tmr_pkg::S_FILT};
      tmr_pkg::A_CFG2: r = {1'b1, tmr_pkg::S_CFG2};
      tmr_pkg::A_CH2_HI_HB: r = {1'b1, tmr_pkg::S_R2HH};
      tmr_pkg::A_CH2_LO_HB: r = {1'b1, tmr_pkg::S_R2LH};
      tmr_pkg::A_CH2_OFS_HI: r = {1'b1, tmr_pkg::S_R2OH};
      tmr_pkg::A_CH2_OFS_LO: r = {1'b1, tmr_pkg::S_R2OL};
      tmr_pkg::A_CH2_HI_LB: r = {1'b1, tmr_pkg::S_R2HL};
      tmr_pkg::A_CH2_LO_LB: r = {1'b1, tmr_pkg::S_R2LL};
      tmr_pkg::A_CH2_OT: r = {1'b1, tmr_pkg::S_R2OT};
      default: ;
    endcase
    return r;
  endfunction

  logic [7:0] ptr_reg, ptr_next;
  logic [7:0] rw_reg [tmr_pkg::NSLOT];
  logic [7:0] rw_next [tmr_pkg::NSLOT];
  tmr_pkg::tmr_meas_t val_reg, val_next;
  logic [7:0] rdata_reg, rdata_next;
  logic rvalid_reg, rvalid_next;
  logic conv_reg, conv_next;
  logic alt_sel;
  logic [5:0] wmap, rmap;

  assign alt_sel = rw_reg[tmr_pkg::S_CFG1][tmr_pkg::CFG1_ALT_BIT];
  assign wmap = map_addr(ptr_reg, alt_sel, 1'b1);
  assign rmap = map_addr(ptr_reg, alt_sel, 1'b0);

  // pointer, register writes, one-shot strobe and read answer
  always_comb begin
    ptr_next = ptr_wr_i ? wdata_i : ptr_reg;
    rw_next = rw_reg;
    // value bytes have no write address, so only the engine updates them
    val_next = meas_valid_i ? meas_i : val_reg;
    if (wr_i && wmap[5]) begin
      if (wmap[4:0] == tmr_pkg::S_FILT) begin
        rw_next[wmap[4:0]] = wdata_i & tmr_pkg::FILT_WR_MASK;
      end else begin
        rw_next[wmap[4:0]] = wdata_i;
      end
    end
    // the strobe is the whole effect: no slot is mapped to this address
    conv_next = wr_i && (ptr_reg == tmr_pkg::WA_ONE_SHOT)
                && rw_reg[tmr_pkg::S_CFG1][tmr_pkg::CFG1_STANDBY_BIT];
    rvalid_next = rd_i;
    rdata_next = rdata_reg;
    if (rd_i) begin
      unique case (ptr_reg)
        tmr_pkg::RA_LOCAL_VAL: rdata_next = val_reg.local_val;
        tmr_pkg::RA_REM_VAL_HI: rdata_next = alt_sel ? val_reg.r2_hi : val_reg.r1_hi;
        tmr_pkg::RA_REM_VAL_LO: rdata_next = alt_sel ? val_reg.r2_lo : val_reg.r1_lo;
        tmr_pkg::RA_CH2_VAL_HI: rdata_next = val_reg.r2_hi;
        tmr_pkg::RA_CH2_VAL_LO: rdata_next = val_reg.r2_lo;
        tmr_pkg::RA_STATUS1: rdata_next = status_first_i;
        tmr_pkg::RA_STATUS2: rdata_next = status_second_i;
        tmr_pkg::RA_PART_ID: rdata_next = PART_ID;
        tmr_pkg::RA_MAKER_ID: rdata_next = MAKER_ID;
        default: rdata_next = rmap[5] ? rw_reg[rmap[4:0]] : 8'h00;
      endcase
    end
  end

  // register stage; slots take their power-on values under reset
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      ptr_reg <= 8'h00;
      for (int i = 0; i < tmr_pkg::NSLOT; i++) begin
        rw_reg[i] <= tmr_pkg::RST_VAL[i];
      end
      val_reg <= {5{tmr_pkg::RST_MEAS}};
      rdata_reg <= 8'h00;
      rvalid_reg <= 1'b0;
      conv_reg <= 1'b0;
    end else begin
      ptr_reg <= ptr_next;
      rw_reg <= rw_next;
      val_reg <= val_next;
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
      conv_reg <= conv_next;
    end
  end

  // fault filtering: one saturating counter per limit
  logic [7:0] filt;
  logic [2:0] thr;
  logic [2:0] cnt_reg [tmr_pkg::NLIM];
  logic [2:0] cnt_next [tmr_pkg::NLIM];
  logic [tmr_pkg::NLIM-1:0] oor;
  logic alert_reg, alert_next;

  assign filt = rw_reg[tmr_pkg::S_FILT];

  always_comb begin
    // odd patterns fall back to a single fault
    unique case (filt[3:1])
      3'h1: thr = 3'h2;
      3'h3: thr = 3'h3;
      3'h7: thr = 3'h4;
      default: thr = 3'h1;
    endcase
    // high limits trip above, low limits trip at or below
    oor[0] = meas_i.local_val > rw_reg[tmr_pkg::S_LHI];
    oor[1] = meas_i.local_val <= rw_reg[tmr_pkg::S_LLO];
    oor[2] = meas_i.r1_hi > rw_reg[tmr_pkg::S_R1HH];
    oor[3] = meas_i.r1_hi <= rw_reg[tmr_pkg::S_R1LH];
    oor[4] = meas_i.r2_hi > rw_reg[tmr_pkg::S_R2HH];
    oor[5] = meas_i.r2_hi <= rw_reg[tmr_pkg::S_R2LH];
    alert_next = 1'b0;
    for (int i = 0; i < tmr_pkg::NLIM; i++) begin
      cnt_next[i] = cnt_reg[i];
      if (meas_valid_i) begin
        if (!oor[i]) cnt_next[i] = 3'h0;
        else if (cnt_reg[i] < 3'h4) cnt_next[i] = cnt_reg[i] + 3'h1;
      end
      // local limits are slots 0 and 1
      if (cnt_next[i] >= thr && !(i < 2 && filt[tmr_pkg::FILT_MASK_LOC_BIT])) begin
        alert_next = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      for (int i = 0; i < tmr_pkg::NLIM; i++) cnt_reg[i] <= 3'h0;
      alert_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      alert_reg <= alert_next;
    end
  end

  // bus timeout watchdog: pins pass three flops, change accepted on 2nd == 3rd
  logic [2:0] scl_sync, sda_sync;
  logic scl_st_reg, scl_st_next, sda_st_reg, sda_st_next;
  logic [22:0] tcnt_reg, tcnt_next;
  logic abort_reg, abort_next;
  logic activity, watch;

  always_comb begin
    scl_st_next = (scl_sync[1] == scl_sync[2]) ? scl_sync[2] : scl_st_reg;
    sda_st_next = (sda_sync[1] == sda_sync[2]) ? sda_sync[2] : sda_st_reg;
    watch = filt[tmr_pkg::FILT_SCL_BIT] || filt[tmr_pkg::FILT_SDA_BIT];
    activity = (filt[tmr_pkg::FILT_SCL_BIT] && (scl_st_next != scl_st_reg))
               || (filt[tmr_pkg::FILT_SDA_BIT] && (sda_st_next != sda_st_reg));
    abort_next = 1'b0;
    tcnt_next = tcnt_reg + 23'h1;
    // counting only inside a transaction keeps an idle bus from tripping it
    if (!bus_busy_i || !watch || activity) begin
      tcnt_next = 23'h0;
    end else if (tcnt_reg == 23'(TIMEOUT_CYC - 1)) begin
      tcnt_next = 23'h0;
      abort_next = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      scl_sync <= 3'h7;
      sda_sync <= 3'h7;
      scl_st_reg <= 1'b1;
      sda_st_reg <= 1'b1;
      tcnt_reg <= 23'h0;
      abort_reg <= 1'b0;
    end else begin
      scl_sync <= {scl_sync[1:0], scl_i};
      sda_sync <= {sda_sync[1:0], sda_i};
      scl_st_reg <= scl_st_next;
      sda_st_reg <= sda_st_next;
      tcnt_reg <= tcnt_next;
      abort_reg <= abort_next;
    end
  end

  // outputs straight from flops
  assign rdata_o = rdata_reg;
  assign rvalid_o = rvalid_reg;
  assign conv_start_o = conv_reg;
  assign bus_abort_o = abort_reg;
  assign fault_alert_o = alert_reg;
  assign rate_sel_o = rw_reg[tmr_pkg::S_RATE];
  assign config_first_o = rw_reg[tmr_pkg::S_CFG1];
  assign hysteresis_o = rw_reg[tmr_pkg::S_HYST];

  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  AST_ONESHOT_STANDBY: assert property (
    wr_i && ptr_reg == tmr_pkg::WA_ONE_SHOT && config_first_o[6] |=> conv_start_o ##1 !conv_start_o)
    else $error("one-shot write in standby gave no single start pulse");
  AST_ONESHOT_NOREAD: assert property (
    rd_i && ptr_reg == tmr_pkg::WA_ONE_SHOT |=> rvalid_o && rdata_o == 8'h00)
    else $error("one-shot address returned stored data");
  AST_FILTER_RESET: assert property (
    $rose(rstn_i) |-> filt == 8'h01 && hysteresis_o == 8'h0A && rate_sel_o == 8'h07)
    else $error("register defaults wrong after reset");
  AST_RATE_SPLIT: assert property (
    wr_i && ptr_reg == tmr_pkg::RA_RATE |=> $stable(rate_sel_o))
    else $error("rate register written at its read address");
  AST_RESERVED_BIT: assert property (
    rd_i && ptr_reg == tmr_pkg::A_FILT |=> rdata_o[4] == 1'b0)
    else $error("reserved filter bit reads one");
  AST_ALIAS_CH2: assert property (
    rd_i && ptr_reg == tmr_pkg::RA_REM_HI_HB && alt_sel
    |=> rdata_o == $past(rw_reg[tmr_pkg::S_R2HH]))
    else $error("aliased remote limit did not reach channel 2");
  AST_COUNT_RESTART: assert property (
    meas_valid_i && !oor[2] |=> cnt_reg[2] == 3'h0)
    else $error("fault counter kept counting after in-limit result");
  AST_ALERT_FILTER: assert property (
    meas_valid_i && filt[3:1] == 3'h7 && !filt[5] && cnt_reg[0] == 3'h3 && oor[0]
    |=> fault_alert_o)
    else $error("four-count filter failed to raise alert");
  AST_MASK_LOCAL: assert property (
    filt[5] && cnt_reg[2] == 3'h0 && cnt_reg[3] == 3'h0 && cnt_reg[4] == 3'h0
    && cnt_reg[5] == 3'h0 && !meas_valid_i |=> !fault_alert_o)
    else $error("masked local limit raised alert");
  AST_TIMEOUT_GATE: assert property (
    bus_abort_o |-> $past(watch, 1) && $past(bus_busy_i, 1))
    else $error("timeout fired while disabled or idle");

  COV_ONESHOT: cover property (conv_start_o);
  COV_ALERT: cover property ($rose(fault_alert_o));
  COV_ABORT: cover property (bus_abort_o);
  COV_ALIAS_WRITE: cover property (wr_i && wmap[5] && alt_sel);

endmodule

`default_nettype wire

// ---- tmr_host_model.sv ----
// tmr_host_model: host side of the register port, one byte per access.
// assumes: the bank takes strobes at the rising edge of clk_i and answers
// a read with rvalid one cycle after the read strobe is taken.
`timescale 1ns/100ps
`default_nettype none

module tmr_host_model (
  // clock
  input wire logic clk_i,
  // register port toward the bank
  output logic ptr_wr_o,
  output logic wr_o,
  output logic rd_o,
  output logic [7:0] wdata_o,
  input wire logic [7:0] rdata_i,
  input wire logic rvalid_i
);
  // strobes idle low from time zero
  initial begin
    ptr_wr_o = 1'b0;
    wr_o = 1'b0;
    rd_o = 1'b0;
    wdata_o = 8'h00;
  end

  // pointer then data; released data shows the inverse so a stale byte never helps
  task automatic reg_write(input logic [7:0] addr, input logic [7:0] data);
    @(posedge clk_i);
    ptr_wr_o <= 1'b1;
    wdata_o <= addr;
    @(posedge clk_i);
    ptr_wr_o <= 1'b0;
    wr_o <= 1'b1;
    wdata_o <= data;
    @(posedge clk_i);
    wr_o <= 1'b0;
    wdata_o <= ~data;
  endtask

  // pointer, read strobe, then a bounded wait for the answer
  task automatic reg_read(input logic [7:0] addr, output logic [7:0] data);
    int n;
    @(posedge clk_i);
    ptr_wr_o <= 1'b1;
    wdata_o <= addr;
    @(posedge clk_i);
    ptr_wr_o <= 1'b0;
    rd_o <= 1'b1;
    wdata_o <= ~addr;
    @(posedge clk_i);
    rd_o <= 1'b0;
    data = 8'hXX;
    for (n = 0; n < 4; n++) begin
      @(posedge clk_i);
      if (rvalid_i === 1'b1) begin
        data = rdata_i;
        break;
      end
    end
  endtask
endmodule
`default_nettype wire

// ---- tmr_testbench.sv ----
// testbench: self-checking bench of the temperature monitor register bank.
// assumes: tmr_pkg and tmr_regbank compiled first; timeout shortened to 20.
`timescale 1ns/100ps
`default_nettype none

module testbench;
  localparam int unsigned TMO = 20;
  // write address, data, read address, expected byte
  localparam logic [31:0] ROWS [14] = '{
    32'h0A5C045C, 32'h0433045C, 32'h0B660566, 32'h0C110611, 32'h0D700770, 32'h0E050805,
    32'h210F210F, 32'h22FF22EF, 32'h10AA1000, 32'h23AA2300, 32'h30AA3000,
    32'h33AA3300, 32'h31443144, 32'h0F990F00};
  // read address, value after reset
  localparam logic [15:0] DEFS [16] = '{
    16'h0407, 16'h0555, 16'h0600, 16'h0755, 16'h0800, 16'h1955, 16'h2055, 16'h210A,
    16'h2201, 16'h2300, 16'h3155, 16'h3955, 16'h0300, 16'h1100, 16'h3400, 16'h3DA7};
  localparam logic [7:0] CODES [4] = '{8'h00, 8'h03, 8'h06, 8'h0F};
  logic clk, rstn, ptr_wr, wr, rd, rvalid, scl, sda, busy, abort, mvalid, conv, alert;
  logic [7:0] wdata, rdata, st1, st2, rate, cfg1, hyst;
  tmr_pkg::tmr_meas_t meas;
  int n_mismatch = 0, num_checks = 0, cyc = 0, n_conv = 0, n_abort = 0;
  int i, t, k, n0;

  tmr_regbank #(
    .TIMEOUT_CYC(TMO),
    .PART_ID(8'hA7), // arbitrary value
    .MAKER_ID(8'h6E) // arbitrary value
  ) dut_u (
    .clk_i(clk), .rstn_i(rstn), .ptr_wr_i(ptr_wr), .wr_i(wr), .rd_i(rd),
    .wdata_i(wdata), .rdata_o(rdata), .rvalid_o(rvalid), .scl_i(scl), .sda_i(sda),
    .bus_busy_i(busy), .bus_abort_o(abort), .meas_valid_i(mvalid), .meas_i(meas),
    .status_first_i(st1), .status_second_i(st2), .conv_start_o(conv),
    .rate_sel_o(rate), .config_first_o(cfg1), .hysteresis_o(hyst),
    .fault_alert_o(alert));

  tmr_host_model host_u (
    .clk_i(clk), .ptr_wr_o(ptr_wr), .wr_o(wr), .rd_o(rd), .wdata_o(wdata),
    .rdata_i(rdata), .rvalid_i(rvalid));

  // 200 MHz clock
  always #2.5 clk = ~clk;

  // pulse counters and run ceiling, far above the roughly 700 cycles used
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (conv === 1'b1) n_conv <= n_conv + 1;
    if (abort === 1'b1) n_abort <= n_abort + 1;
    if (cyc == 40000) begin
      n_mismatch++;
      close_out();
    end
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
    logic [7:0] got;
    host_u.reg_read(addr, got);
    check(got, exp);
  endtask

  // reset is synchronous, so it is held over eight edges
  task automatic do_reset();
    rstn <= 1'b0;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
  endtask

  // one measurement pulse; alert is looked at well after it settles
  task automatic measure(input logic [7:0] loc, input logic [7:0] r1, input logic [7:0] r2);
    @(posedge clk);
    mvalid <= 1'b1;
    meas <= {loc, r1, 8'h00, r2, 8'h00};
    @(posedge clk);
    mvalid <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask

  // busy bus for 60 cycles; lines move every 4 cycles so the pin filter accepts them
  task automatic tmo_run(input logic [7:0] filt, input logic ts, input logic td, input logic ex);
    host_u.reg_write(8'h22, filt);
    n0 = n_abort;
    busy <= 1'b1;
    repeat (15) begin
      repeat (4) @(posedge clk);
      scl <= scl ^ ts;
      sda <= sda ^ td;
    end
    busy <= 1'b0;
    repeat (2) @(posedge clk);
    check({7'h00, n_abort != n0}, {7'h00, ex});
  endtask

  initial begin
    {clk, rstn, mvalid, busy} = 4'h0;
    {scl, sda} = 2'b11;
    {st1, st2} = 16'h0000;
    meas = '0;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    // split addresses, read-only places, reserved bit and one-shot byte
    for (i = 0; i < 14; i++) begin
      host_u.reg_write(ROWS[i][31:24], ROWS[i][23:16]);
      rd_chk(ROWS[i][15:8], ROWS[i][7:0]);
    end
    check(8'(n_conv), 8'h00);
    $display("test register map done");
    // second reset after writes brings every default back
    do_reset();
    for (i = 0; i < 16; i++) begin
      rd_chk(DEFS[i][15:8], DEFS[i][7:0]);
    end
    check(rate, 8'h07);
    check(hyst, 8'h0A);
    check(cfg1, 8'h00);
    $display("test reset values done");
    // alias bit steers shared addresses and offsets to channel 2
    host_u.reg_write(8'h09, 8'h08);
    host_u.reg_write(8'h0D, 8'h60);
    host_u.reg_write(8'h11, 8'h12);
    rd_chk(8'h31, 8'h60);
    rd_chk(8'h34, 8'h12);
    rd_chk(8'h07, 8'h60);
    host_u.reg_write(8'h09, 8'h00);
    rd_chk(8'h07, 8'h55);
    rd_chk(8'h11, 8'h00);
    $display("test channel alias done");
    // every count code, bit 0 set in two of them; host raises the count
    for (t = 0; t < 4; t++) begin
      host_u.reg_write(8'h22, CODES[t]);
      measure(8'h20, 8'h20, 8'h20);
      for (k = 1; k <= 4; k++) begin
        measure(8'h60, 8'h20, 8'h20);
        check({7'h00, alert}, {7'h00, k > t});
      end
      measure(8'h20, 8'h20, 8'h20);
      check({7'h00, alert}, 8'h00);
    end
    // an in-limit result between two faults restarts the count
    host_u.reg_write(8'h22, 8'h02);
    measure(8'h60, 8'h20, 8'h20);
    measure(8'h20, 8'h20, 8'h20);
    measure(8'h60, 8'h20, 8'h20);
    check({7'h00, alert}, 8'h00);
    // local mask hides local faults only
    host_u.reg_write(8'h22, 8'h20);
    measure(8'h60, 8'h20, 8'h20);
    check({7'h00, alert}, 8'h00);
    measure(8'h20, 8'h60, 8'h30);
    check({7'h00, alert}, 8'h01);
    rd_chk(8'h01, 8'h60);
    rd_chk(8'h30, 8'h30);
    host_u.reg_write(8'h09, 8'h08);
    rd_chk(8'h01, 8'h30);
    $display("test fault filter done");
    // one-shot only from standby; alert is not looked at meanwhile
    host_u.reg_write(8'h09, 8'h40);
    n0 = n_conv;
    host_u.reg_write(8'h0F, 8'hA5);
    repeat (2) @(posedge clk);
    check(8'(n_conv - n0), 8'h01);
    rd_chk(8'h0F, 8'h00);
    $display("test one-shot done");
    // timeout enables, each against a moving and a still line
    tmo_run(8'h01, 1'b0, 1'b0, 1'b0);
    tmo_run(8'h81, 1'b0, 1'b1, 1'b1);
    tmo_run(8'h81, 1'b1, 1'b0, 1'b0);
    tmo_run(8'h41, 1'b0, 1'b0, 1'b1);
    tmo_run(8'h41, 1'b0, 1'b1, 1'b0);
    $display("test bus timeout done");
    close_out();
  end
endmodule
`default_nettype wire
